// >>> tlcfg_top.sv
// Trip level decode and load check configuration with AXI4-Lite registers
`timescale 1ns/1ps
// What this block does
// - Register codes 010..111 map to 1.41..2.97 V
// - Code 000 disables regulation, 001 is 1.18 V
// - Pre-production parts use shifted threshold map
// - Pin variant follows threshold pin level immediately
// - Serial threshold bits writable anytime, applied immediately
// - Serial flag sets when current reaches regulation level while driving
// - Trip event never drives the fault output
// - Flag holds until clear-faults command clears it
// - Bridge modes idle: setting only enables off-checking
// - Independent idle: setting enables and selects combination
// - Driving state: high-side load masks regulation
// - Serial driving: low-side load masks open detect
// - Pin driving: load-check pin picks retry or latch
// - Six-level pin; bridge level one off/retry
// - Independent pin levels one to three decode
// - Independent pin levels four to six decode
// - Pin high-side: checking off only when disable high, input low
// - Load-check pin sampled once at wake, then ignored
// - Serial load-check is 2-bit field in setup two
// - Serial bridge: 00 off, others on; diagnostics kept
// - Serial independent decodes low/high side and check
// - Serial load-check field writable anytime, applied immediately

// Outputs lag their inputs by one clock.
// Bus answers come a clock after a take.
// One write and one read in flight.

module tlcfg_top
  import tlcfg_pkg::*;
#(
  parameter int AW = 8  // Register address width
) (
  // Clock and reset
  input  wire logic          mclk,
  input  wire logic          nrst,
  // Variant and state
  input  wire logic          pin_variant,      // High: strap pins in use
  input  wire logic          driving_state,    // High: active, low: idle
  input  wire logic          wake_init,        // Pulse at wake or power-up
  // Strap pins, level 1..6 encoded as 0..5
  input  wire logic [2:0]    threshold_level,
  input  wire logic [2:0]    load_check_level,
  input  wire logic [1:0]    pin_mode,         // Mode straps for pin variant
  input  wire logic          driver_disable_pin,
  input  wire logic          input_pin,
  // Comparator from sense_current_out path
  input  wire logic          trip_cmp,
  input  wire logic          fault_in,         // Other protection faults
  // Decoded outputs
  // All come straight from flip-flops
  output logic [11:0]        regulation_threshold, // Trip level in mV
  output logic               regulation_enable,
  output logic               offstate_load_check,
  output logic [1:0]         offstate_combo,   // Combination selector
  output logic               high_side_load,
  output logic               onstate_open_detect,
  output logic               latch_reaction,   // High latch, low retry
  output logic               fault_out_n,
  // Register bus, one word per register
  // AXI4-Lite write address
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [AW-1:0] s_axi_awaddr,
  // AXI4-Lite write data
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  // AXI4-Lite write response
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  output logic [1:0]         s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  input  wire logic [AW-1:0] s_axi_araddr,
  // AXI4-Lite read data
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp
);

  // Software registers
  // Reset leaves regulation off
  logic [2:0]    thr_sel;        // threshold_select_bits
  logic [1:0]    load_check_setting_bits;      // load_check_bits
  logic [1:0]    mode_reg;       // Serial bridge mode
  logic          preprod;        // Pre-production mapping
  logic          trip_flag;      // threshold_reached_flag
  logic [2:0]    load_check_setting_latched;   // Load-check pin captured at wake

  // Write channel holding
  logic          aw_held;        // Address taken, waiting for data
  logic          w_held;         // Data taken, waiting for address
  logic [AW-1:0] aw_addr;
  logic [31:0]   w_data;
  logic [3:0]    w_strb;

  // Threshold decode: normal and pre-production tables
  // Used by both variants
  function automatic logic [11:0] thr_mv(input logic [2:0] code,
                                         input logic pre);
    logic [11:0] mv;
    // Defined for every code
    mv = MV_OFF;
    // Normal map, then pre-production
    if (!pre) begin
      unique case (code)
        3'h0: mv = MV_OFF;
        3'h1: mv = MV_1180;
        3'h2: mv = MV_1410;
        3'h3: mv = MV_1650;
        3'h4: mv = MV_1980;
        3'h5: mv = MV_2310;
        3'h6: mv = MV_2640;
        3'h7: mv = MV_2970;
      endcase
    end else begin
      unique case (code)
        3'h0: mv = MV_OFF;
        3'h1: mv = MV_1650;
        3'h2: mv = MV_1980;
        3'h3: mv = MV_2310;
        3'h4: mv = MV_2640;
        3'h5, 3'h6, 3'h7: mv = MV_2970;
      endcase
    end
    return mv;
  endfunction

  // Pin level to code: levels one and two give 000 and 001, rest 100..111
  // Codes 010 and 011: software only
  wire [2:0] lvl_code = (threshold_level < 3'h2) ? threshold_level
                      : (threshold_level + 3'h2);

  // Pre-production parts use the level index directly
  wire [2:0] pin_code = preprod ? threshold_level : lvl_code;
  // Pin variant is transparent; serial uses register at once
  wire [2:0] eff_code = pin_variant ? pin_code : thr_sel;

  // Mode from straps or setup one
  wire [1:0] eff_mode = pin_variant ? pin_mode : mode_reg;
  // Independent mode alters both decodes
  wire       indep    = (eff_mode == 2'(TLCFG_INDEP));

  // Pin-variant load-check decode of latched level (0..5 = levels 1..6)
  // Latched, so straps cannot move it
  wire       p_lvl1   = (load_check_setting_latched == 3'h0);
  wire       p_hs     = indep && (load_check_setting_latched == 3'h2);
  wire       p_check  = !p_lvl1;
  wire       p_regdis = indep && ((load_check_setting_latched == 3'h2) ||
                                  (load_check_setting_latched == 3'h3));

  // Latch reaction: bridge any level but one; independent 2,3,5
  wire       p_latch  = indep ? ((load_check_setting_latched == 3'h1) ||
                                 (load_check_setting_latched == 3'h2) ||
                                 (load_check_setting_latched == 3'h4))
                              : !p_lvl1;

  // High-side checking only stopped by disable high and input low
  // No strap level turns it off
  wire       p_hs_off = p_hs && driver_disable_pin && !input_pin;
  wire       p_chk_fin = p_hs ? (p_check && !p_hs_off) : p_check;

  // Serial-variant decode of the 2-bit field
  // Field is live after each write
  wire       s_check  = indep ? load_check_setting_bits[0] : (load_check_setting_bits != 2'h0);
  wire       s_hs     = indep && load_check_setting_bits[1];

  // Open detect disabled for low-side independent loads only
  wire       s_opdet  = !(indep && !load_check_setting_bits[1]);

  // Pick the fitted variant
  wire       dec_hs     = pin_variant ? p_hs : s_hs;
  wire       dec_regdis = pin_variant ? p_regdis : s_hs;
  wire       dec_check  = pin_variant ? p_chk_fin : s_check;

  // Combination select only meaningful in independent mode
  wire [1:0] dec_combo  = !indep ? 2'h0
                        : (pin_variant ? load_check_setting_latched[1:0] : load_check_setting_bits);
  // Needs a trip level and no regulation mask from the load decode
  wire       reg_on     = (eff_code != 3'h0) && !dec_regdis;

  // Decoded outputs, registered
  // Glitch-free pins cost one clock
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      // All off, fault pin high
      regulation_threshold <= MV_OFF;
      regulation_enable    <= 1'b0;
      offstate_load_check  <= 1'b0;
      offstate_combo       <= 2'h0;
      high_side_load       <= 1'b0;
      onstate_open_detect  <= 1'b0;
      latch_reaction       <= 1'b0;
      fault_out_n          <= 1'b1;
    end else begin
      // Level follows the effective code
      regulation_threshold <= thr_mv(eff_code, preprod);
      // Regulation only acts while driving
      regulation_enable    <= reg_on && driving_state;
      // Off-state checking only in idle
      offstate_load_check  <= dec_check && !driving_state;
      offstate_combo       <= dec_combo;
      // Load type shown in both states
      high_side_load       <= dec_hs;
      // Open detect: serial part, driving
      onstate_open_detect  <= driving_state && !pin_variant && s_opdet;
      // Fault reaction: straps only
      latch_reaction       <= pin_variant && p_latch;

      // Trip events deliberately excluded from the fault pin
      fault_out_n          <= !fault_in;
    end
  end

  // Load-check pin captured once per wake; later changes ignored
  // Only a wake can change it
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      load_check_setting_latched <= 3'h0;
    end else if (wake_init) begin
      // Held until the next wake
      load_check_setting_latched <= load_check_level;
    end
  end

  // AXI write decode
  // Held copy stands in for a channel
  wire          aw_take  = s_axi_awvalid && s_axi_awready;
  wire          w_take   = s_axi_wvalid && s_axi_wready;
  wire          aw_have  = aw_held || aw_take;
  wire          w_have   = w_held || w_take;
  wire [AW-1:0] wr_addr  = aw_held ? aw_addr : s_axi_awaddr;
  wire [31:0]   wr_data  = w_held ? w_data : s_axi_wdata;
  wire [3:0]    wr_strb  = w_held ? w_strb : s_axi_wstrb;
  // Fire when both halves are here
  wire          wr_go    = aw_have && w_have && !s_axi_bvalid;
  // Off-map writes get an error
  wire          wr_map   = (wr_addr == AW'(OFS_SETUP_ONE)) ||
                           (wr_addr == AW'(OFS_SETUP_TWO)) ||
                           (wr_addr == AW'(OFS_ACT_STATUS)) ||
                           (wr_addr == AW'(OFS_COMMAND)) ||
                           (wr_addr == AW'(OFS_DECODE));
  // Status and decode drop writes
  wire          wr_one   = wr_go && (wr_addr == AW'(OFS_SETUP_ONE));
  wire          wr_two   = wr_go && (wr_addr == AW'(OFS_SETUP_TWO)) &&
                           wr_strb[0];
  wire          clr_cmd  = wr_go && (wr_addr == AW'(OFS_COMMAND)) &&
                           wr_strb[0] && wr_data[CLR_BIT];

  // Write channel acceptance and response
  // A new write waits past bready
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      // Nothing held, no answer
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= '0;
      w_data        <= 32'h0;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      // Hold whichever channel arrived first
      // Holds clear when the write fires
      aw_held       <= aw_have && !wr_go;
      w_held        <= w_have && !wr_go;
      if (aw_take) begin
        aw_addr <= s_axi_awaddr;
      end
      if (w_take) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end

      // Ready only while that channel is empty and no response pending
      s_axi_awready <= !aw_have && !s_axi_bvalid && !wr_go;
      s_axi_wready  <= !w_have && !s_axi_bvalid && !wr_go;
      // Answer stands until taken
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_map ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Configuration registers, applied on the write cycle
  // Byte lanes gate the fields
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      thr_sel   <= THR_RST;
      mode_reg  <= MODE_RST;
      preprod   <= 1'b0;
      load_check_setting_bits <= LOAD_CHECK_SETTING_RST;
    end else begin
      if (wr_one && wr_strb[0]) begin
        thr_sel  <= wr_data[THR_LSB +: 3];
        mode_reg <= wr_data[MODE_LSB +: 2];
      end
      // Map select is in byte one
      if (wr_one && wr_strb[1]) begin
        preprod <= wr_data[PREPROD_BIT];
      end
      // New field used next clock
      if (wr_two) begin
        load_check_setting_bits <= wr_data[LOAD_CHECK_SETTING_LSB +: 2];
      end
    end
  end

  // Trip flag: set beats clear in the same cycle
  // Serial part only; pins never set it
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      trip_flag <= 1'b0;
    end else if (!pin_variant && trip_cmp && reg_on && driving_state) begin
      trip_flag <= 1'b1;
    end else if (clr_cmd) begin
      trip_flag <= 1'b0;
    end
  end

  // Read data selection
  // Decoded from the address
  wire [31:0] rd_one = {23'h0, preprod, 2'h0, mode_reg, 1'b0, thr_sel};
  // Shows what the pins are given
  wire [31:0] rd_dec = {19'h0, load_check_setting_latched, eff_code, latch_reaction,
                        onstate_open_detect, high_side_load,
                        offstate_combo, offstate_load_check,
                        regulation_enable};
  // Off-map reads give zero, error
  wire        rd_map = (s_axi_araddr == AW'(OFS_SETUP_ONE)) ||
                       (s_axi_araddr == AW'(OFS_SETUP_TWO)) ||
                       (s_axi_araddr == AW'(OFS_ACT_STATUS)) ||
                       (s_axi_araddr == AW'(OFS_COMMAND)) ||
                       (s_axi_araddr == AW'(OFS_DECODE));
  wire [31:0] rd_val =
      (s_axi_araddr == AW'(OFS_SETUP_ONE))  ? rd_one
    : (s_axi_araddr == AW'(OFS_SETUP_TWO))  ? {30'h0, load_check_setting_bits}
    : (s_axi_araddr == AW'(OFS_ACT_STATUS)) ? {31'h0, trip_flag}
    : (s_axi_araddr == AW'(OFS_DECODE))     ? rd_dec
    : 32'h0;
  wire        ar_take = s_axi_arvalid && s_axi_arready;

  // Read channel: one outstanding read
  // arready drops until rready
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !ar_take;
      // Capture as the address is taken
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_val;
        s_axi_rresp  <= rd_map ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

// >>> tlcfg_pkg.sv
// Package: constants for the trip level and load check configuration block
package tlcfg_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_SETUP_ONE   = 8'h00; // Threshold select, mode
  localparam logic [7:0] OFS_SETUP_TWO   = 8'h04; // setup_reg_two
  localparam logic [7:0] OFS_ACT_STATUS  = 8'h08; // active_status_reg
  localparam logic [7:0] OFS_COMMAND     = 8'h0c; // Command register
  localparam logic [7:0] OFS_DECODE      = 8'h10; // Decoded effects, read only
  // Field positions
  localparam int THR_LSB      = 0;  // threshold_select_bits [2:0]
  localparam int MODE_LSB     = 4;  // Bridge mode [5:4]
  localparam int PREPROD_BIT  = 8;  // Pre-production threshold map
  localparam int LOAD_CHECK_SETTING_LSB     = 0;  // load_check_bits [1:0]
  localparam int TRIP_BIT     = 0;  // threshold_reached_flag
  localparam int CLR_BIT      = 0;  // clear_faults_cmd
  // Reset values
  localparam logic [2:0] THR_RST  = 3'h0;
  localparam logic [1:0] LOAD_CHECK_SETTING_RST = 2'h0;
  localparam logic [1:0] MODE_RST = 2'h0;
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Trip voltage in millivolts; zero means regulation disabled
  localparam logic [11:0] MV_OFF  = 12'h000;
  localparam logic [11:0] MV_1180 = 12'h49c;
  localparam logic [11:0] MV_1410 = 12'h582;
  localparam logic [11:0] MV_1650 = 12'h672;
  localparam logic [11:0] MV_1980 = 12'h7bc;
  localparam logic [11:0] MV_2310 = 12'h906;
  localparam logic [11:0] MV_2640 = 12'ha50;
  localparam logic [11:0] MV_2970 = 12'hb9a;
  // Bridge modes
  typedef enum logic [1:0] {
    TLCFG_PHASE_ENABLE_MODE, TLCFG_PWM, TLCFG_INDEP
  } tlcfg_mode_e;
endpackage

// >>> tlcfg_checker.sv
// Checker: port assertions for the trip level and load check block
`timescale 1ns/1ps
module tlcfg_checker
  import tlcfg_pkg::*;
(
  // Clock, reset and controls
  input wire logic        mclk,
  input wire logic        nrst,
  input wire logic        pin_variant,
  input wire logic        driving_state,
  input wire logic [2:0]  threshold_level,
  input wire logic        fault_in,
  // Decoded outputs
  input wire logic [11:0] regulation_threshold,
  input wire logic        regulation_enable,
  input wire logic        offstate_load_check,
  input wire logic        high_side_load,
  input wire logic        onstate_open_detect,
  input wire logic        latch_reaction,
  input wire logic        fault_out_n,
  // Write response handshake
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  logic [11:0] pin_mv; // Expected strap level in mV, one cycle late
  // Level two is left out: it hangs on the hidden pre-production bit
  always_ff @(posedge mclk) begin
    case (threshold_level)
      3'h0:    pin_mv <= MV_OFF;
      3'h2:    pin_mv <= MV_1980;
      3'h3:    pin_mv <= MV_2310;
      3'h4:    pin_mv <= MV_2640;
      default: pin_mv <= MV_2970;
    endcase
  end
  a_fault_follows: assert property ($past(nrst)
    |-> fault_out_n == !$past(fault_in)) else $error("fault out wrong");
  a_off_disables: assert property (regulation_threshold == MV_OFF
    |-> !regulation_enable) else $error("enable with code off");
  a_high_masks: assert property (high_side_load
    |-> !regulation_enable) else $error("high side not masked");
  a_enable_driving: assert property (regulation_enable
    |-> $past(driving_state)) else $error("enable while idle");
  a_offchk_idle: assert property (offstate_load_check
    |-> !$past(driving_state)) else $error("off check while driving");
  a_latch_pin: assert property (latch_reaction
    |-> $past(pin_variant)) else $error("latch in serial variant");
  a_opendet_serial: assert property (onstate_open_detect
    |-> !$past(pin_variant) && $past(driving_state))
    else $error("open detect misplaced");
  a_pin_level: assert property ($past(nrst) && $past(pin_variant)
    && $past(threshold_level) != 3'h1 && $past(threshold_level) < 3'h6
    |-> regulation_threshold == pin_mv) else $error("pin threshold");
  a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid) else $error("bvalid dropped");
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_high: cover property (high_side_load);
  c_pin_en: cover property (pin_variant && regulation_enable);
endmodule
bind tlcfg_top tlcfg_checker u_chk (
  .mclk(mclk), .nrst(nrst), .pin_variant(pin_variant),
  .driving_state(driving_state), .threshold_level(threshold_level),
  .fault_in(fault_in), .regulation_threshold(regulation_threshold),
  .regulation_enable(regulation_enable),
  .offstate_load_check(offstate_load_check),
  .high_side_load(high_side_load),
  .onstate_open_detect(onstate_open_detect),
  .latch_reaction(latch_reaction), .fault_out_n(fault_out_n),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready)
);

// >>> tlcfg_host.sv
// Host model: AXI4-Lite master in place of the controller
`timescale 1ns/1ps
module tlcfg_host (
  // Clock
  input  wire logic   mclk,
  // Write channels
  output logic        awvalid,
  input  wire logic   awready,
  output logic [7:0]  awaddr,
  output logic        wvalid,
  input  wire logic   wready,
  output logic [31:0] wdata,
  output logic [3:0]  wstrb,
  input  wire logic   bvalid,
  output logic        bready,
  // Read channels
  output logic        arvalid,
  input  wire logic   arready,
  output logic [7:0]  araddr,
  input  wire logic   rvalid,
  output logic        rready
);
  // Idle bus from time zero
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
  end
  // One write; slow keeps bready low until the answer shows
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic slow);
    @(posedge mclk);
    awvalid <= 1'b1;
    awaddr  <= a;
    wvalid  <= 1'b1;
    wdata   <= d;
    wstrb   <= 4'hf;
    bready  <= !slow;
    do begin
      @(posedge mclk);
      // Released lines flip so stale values never look valid
      if (awvalid && awready) begin
        awvalid <= 1'b0;
        awaddr  <= ~a;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
        wdata  <= ~d;
      end
      if (bvalid && !bready) bready <= 1'b1;
    end while (!(bvalid && bready));
    bready <= 1'b0;
  endtask
  // One read, same pacing choice
  task automatic rd(input logic [7:0] a, input logic slow);
    @(posedge mclk);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= !slow;
    do begin
      @(posedge mclk);
      if (arvalid && arready) begin
        arvalid <= 1'b0;
        araddr  <= ~a;
      end
      if (rvalid && !rready) rready <= 1'b1;
    end while (!(rvalid && rready));
    rready <= 1'b0;
  endtask
endmodule

// >>> tlcfg_top_tb.sv
// Testbench: trip level and load check configuration block
`timescale 1ns/1ps
module tlcfg_top_tb;
  import tlcfg_pkg::*;
  logic mclk, nrst, pin_variant, driving_state, wake_init, trip_cmp;
  logic fault_in, driver_disable_pin, input_pin, regulation_enable;
  logic offstate_load_check, high_side_load, onstate_open_detect;
  logic latch_reaction, fault_out_n, awvalid, awready, wvalid, wready;
  logic bvalid, bready, arvalid, arready, rvalid, rready;
  logic [2:0] threshold_level, load_check_level, lat_l, ts;
  logic [1:0] pin_mode, offstate_combo, bresp, rresp, ms, ds;
  logic [11:0] regulation_threshold;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [31:0] exp_q [$]; // Expected answers, oldest first
  logic [1:0] rsp_q [$]; // Expected read responses
  int errors, cmp_count;
  tlcfg_top uut (
    .mclk(mclk), .nrst(nrst), .pin_variant(pin_variant),
    .driving_state(driving_state), .wake_init(wake_init),
    .threshold_level(threshold_level), .load_check_level(load_check_level),
    .pin_mode(pin_mode), .driver_disable_pin(driver_disable_pin),
    .input_pin(input_pin), .trip_cmp(trip_cmp), .fault_in(fault_in),
    .regulation_threshold(regulation_threshold),
    .regulation_enable(regulation_enable),
    .offstate_load_check(offstate_load_check),
    .offstate_combo(offstate_combo), .high_side_load(high_side_load),
    .onstate_open_detect(onstate_open_detect),
    .latch_reaction(latch_reaction), .fault_out_n(fault_out_n),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp)
  );
  tlcfg_host host (
    .mclk(mclk), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready)
  );
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  task automatic chk(input string nm, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Each answer on the bus is matched against the oldest note
  always @(posedge mclk) begin
    if (bvalid && bready) chk("bresp", exp_q.pop_front(), 32'(bresp));
    if (rvalid && rready) chk("rdata", exp_q.pop_front(), rdata);
    if (rvalid && rready) chk("rresp", 32'(rsp_q.pop_front()), 32'(rresp));
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d, e);
    exp_q.push_back(e);
    host.wr(a, d, 1'($urandom));
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] r = RESP_OKAY);
    exp_q.push_back(e);
    rsp_q.push_back(r);
    host.rd(a, 1'($urandom));
  endtask
  function automatic logic [11:0] mv(input logic [2:0] c, input logic pre);
    logic [11:0] n [8];
    logic [11:0] r [8];
    n = '{MV_OFF, MV_1180, MV_1410, MV_1650,
          MV_1980, MV_2310, MV_2640, MV_2970};
    r = '{MV_OFF, MV_1650, MV_1980, MV_2310,
          MV_2640, MV_2970, MV_2970, MV_2970};
    return pre ? r[c] : n[c];
  endfunction
  // Expected decode word, built from the tables and latched strap
  function automatic logic [31:0] dec(input logic p, v,
      input logic [1:0] m, d, input logic [2:0] c, input logic a, b);
    logic ind, hs, en, off, lat, od;
    logic [1:0] cb;
    ind = (m == 2'h2);
    hs  = ind && (p ? lat_l == 3'h2 : d[1]);
    en  = v && c != 3'h0 && !hs && !(p && ind && lat_l == 3'h3);
    off = !v && (p ? lat_l != 3'h0 && !(hs && a && !b)
                   : (ind ? d[0] : d != 2'h0));
    lat = p && (ind ? lat_l inside {3'h1, 3'h2, 3'h4} : lat_l != 3'h0);
    od  = !p && v && !(ind && !d[1]);
    cb  = !ind ? 2'h0 : (p ? lat_l[1:0] : d);
    return {19'h0, lat_l, c, lat, od, hs, cb, off, en};
  endfunction
  // Set pins and registers, then check threshold and decode word
  task automatic step(input logic p, v, pre, input logic [1:0] m, d,
                      input logic [2:0] t);
    logic a, b;
    logic [2:0] c;
    logic [31:0] e;
    a = 1'($urandom);
    b = 1'($urandom);
    c = (p && !pre && t > 3'h1) ? t + 3'h2 : t;
    @(posedge mclk);
    pin_variant <= p;
    driving_state <= v;
    pin_mode <= m;
    threshold_level <= t;
    driver_disable_pin <= a;
    input_pin <= b;
    fault_in <= 1'($urandom);
    wr(OFS_SETUP_ONE, {23'h0, pre, 2'h0, m, 1'b0, t}, 32'(RESP_OKAY));
    wr(OFS_SETUP_TWO, {30'h0, d}, 32'(RESP_OKAY));
    repeat (2) @(posedge mclk);
    #1;
    e = 32'(mv(c, pre));
    chk("threshold", e, 32'(regulation_threshold));
    e = dec(p, v, m, d, c, a, b);
    rd(OFS_DECODE, e);
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    {nrst, pin_variant, driving_state, wake_init, trip_cmp} = '0;
    {fault_in, driver_disable_pin, input_pin, pin_mode} = '0;
    {threshold_level, load_check_level, lat_l, ts, ms, ds} = '0;
    errors = 0;
    cmp_count = 0;
    void'($urandom(88048));
    repeat (8) @(posedge mclk);
    nrst <= 1'b1;
    // Reset values, an unmapped write and a write to read-only status
    for (int i = 0; i < 5; i++) rd(8'(4 * i), 32'h0);
    wr(8'h14, 32'h1, 32'(RESP_SLVERR));
    rd(8'h14, 32'h0, RESP_SLVERR);
    wr(OFS_ACT_STATUS, 32'h1, 32'(RESP_OKAY));
    rd(OFS_ACT_STATUS, 32'h0);
    $display("test reset done");
    // Every code in both maps, random mode and load setting
    for (int i = 0; i < 32; i++) begin
      ms = 2'($urandom % 3);
      ds = 2'($urandom);
      step(1'b0, i[4], i[3], ms, ds, i[2:0]);
    end
    $display("test serial done");
    // Trip while driving sets the flag, while idle it does not
    for (int k = 1; k >= 0; k--) begin
      step(1'b0, k[0], 1'b0, 2'h0, 2'h0, 3'h4);
      @(posedge mclk);
      trip_cmp <= 1'b1;
      @(posedge mclk);
      trip_cmp <= 1'b0;
      chk("fault_out_n", 32'(!fault_in), 32'(fault_out_n));
      rd(OFS_ACT_STATUS, 32'(k));
      rd(OFS_ACT_STATUS, 32'(k));
      wr(OFS_COMMAND, 32'h1, 32'(RESP_OKAY));
      rd(OFS_ACT_STATUS, 32'h0);
    end
    $display("test flag done");
    // Strap variant: latch a level at wake, then move the pin away
    pin_variant <= 1'b1;
    for (int i = 0; i < 18; i++) begin
      @(posedge mclk);
      lat_l <= 3'(i % 6);
      load_check_level <= 3'(i % 6);
      wake_init <= 1'b1;
      @(posedge mclk);
      wake_init <= 1'b0;
      load_check_level <= 3'($urandom % 6);
      ms = 2'(i / 6);
      ds = 2'($urandom);
      ts = 3'($urandom % 6);
      step(1'b1, 1'($urandom), 1'($urandom), ms, ds, ts);
    end
    $display("test strap done");
    complete_run();
  end
  // Watchdog well beyond the thousand or so cycles the tests need
  initial begin
    #100000;
    errors++;
    $display("ERROR watchdog expected finish seen hang");
    complete_run();
  end
endmodule
